/* File: pkg/led_pwm_pkg.sv */
// Purpose: Shared constants and types for the four-channel LED PWM and current block
// Assumes: 8-bit register space, 100 MHz system clock
// Notes: Channel index order everywhere is blue, green, red, white (0..3)
package led_pwm_pkg;
    localparam logic [7:0] ENABLE_ADDR = 8'h00;
    localparam logic [7:0] MODE_ADDR = 8'h01;
    localparam logic [7:0] BLUE_PWM_ADDR = 8'h02;
    localparam logic [7:0] GREEN_PWM_ADDR = 8'h03;
    localparam logic [7:0] RED_PWM_ADDR = 8'h04;
    localparam logic [7:0] WHITE_PWM_ADDR = 8'h0e;
    localparam logic [7:0] BLUE_CUR_ADDR = 8'h05;
    localparam logic [7:0] GREEN_CUR_ADDR = 8'h06;
    localparam logic [7:0] RED_CUR_ADDR = 8'h06;
    localparam logic [7:0] WHITE_CUR_ADDR = 8'h07;
    localparam logic [7:0] CONFIG_ADDR = 8'h08;
    localparam logic [7:0] MAP_ADDR = 8'h70;
    localparam logic [3:0][7:0] DUTY_ADDRS = {WHITE_PWM_ADDR, RED_PWM_ADDR, GREEN_PWM_ADDR, BLUE_PWM_ADDR};
    localparam logic [3:0][7:0] CUR_ADDRS = {WHITE_CUR_ADDR, RED_CUR_ADDR, GREEN_CUR_ADDR, BLUE_CUR_ADDR};

    localparam logic [7:0] CURRENT_RESET = 8'haf;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [6:0] BUS_ADDR_RESET = 7'h30;

    localparam int LOG_EN_BIT = 7;
    localparam int CHIP_EN_BIT = 6;
    localparam int FAST_RATE_BIT = 6;
    localparam int INT_CLK_BIT = 0;
    localparam int FIRST_ENGINE_POS = 4;
    localparam int SECOND_ENGINE_POS = 2;
    localparam int THIRD_ENGINE_POS = 0;
    localparam int SELECT_WIDTH = 2;

    localparam int CLOCK_HZ = 100_000_000;
    localparam int SLOW_RATE_HZ = 256;
    localparam int FAST_RATE_HZ = 558;
    localparam int PWM_STEPS = 256;
    localparam int SLOW_DIV = CLOCK_HZ / (SLOW_RATE_HZ * PWM_STEPS);
    localparam int FAST_DIV = CLOCK_HZ / (FAST_RATE_HZ * PWM_STEPS);

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_LOAD = 2'b01,
        MODE_RUN = 2'b10,
        MODE_DIRECT = 2'b11
    } engine_mode_e;

    typedef enum logic [1:0] {
        SRC_OWN = 2'b00,
        SRC_ENG1 = 2'b01,
        SRC_ENG2 = 2'b10,
        SRC_ENG3 = 2'b11
    } source_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_REG = 4'b0011,
        ST_REG_ACK = 4'b0100,
        ST_WRITE = 4'b0101,
        ST_WRITE_ACK = 4'b0110,
        ST_READ = 4'b0111,
        ST_READ_ACK = 4'b1000
    } bus_state_e;

    typedef struct packed {
        logic [7:0] white;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } chan_bytes_s;
endpackage : led_pwm_pkg

/* File: logic/channel_drive.sv */
// Purpose: Per-channel duty shaping and period compare
// Assumes: count advances once per PWM step from a shared counter
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module channel_drive
    import led_pwm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] duty, // Selected duty code
    input wire logic log_scale, // Logarithmic shaping on
    input wire logic [WIDTH-1:0] count, // Shared period counter
    output logic on // Output conducts this step
);
    logic [2*WIDTH-1:0] plus_one;
    logic [2*WIDTH-1:0] square;
    logic [WIDTH-1:0] level;

    // Squared curve: (d+1)^2-1 keeps 0 at 0 and full code at full, wraps cleanly
    always_comb begin
        plus_one = {{WIDTH{1'b0}}, duty} + {{(2*WIDTH-1){1'b0}}, 1'b1};
        square = plus_one * plus_one - {{(2*WIDTH-1){1'b0}}, 1'b1}; // [R16]
        level = log_scale ? square[2*WIDTH-1:WIDTH] : duty; // [R10]
        on = (level == {WIDTH{1'b1}}) || (count < level); // [R4] [R17]
    end
endmodule : channel_drive
`default_nettype wire

/* File: logic/led_channel_pwm_current_control.sv */
// Purpose: Four-channel LED PWM and sink current control behind a two-wire serial slave
// Assumes: scl and sda_in synchronous to clock; engine programs run outside this block
// Notes: engine programs run outside; their run-mode duty arrives on a port
// Contract
// R1: Eight-bit current code, 0.1 mA steps
// R2: Current registers reset to code 175
// R3: Own duty register per output at its address
// R4: Duty zero is off, all-ones always on
// R5: Per-output source selectors in map register
// R6: Selector 00 own register, else engine
// R7: Direct-mode engine takes blue/green/red duty
// R8: Duty writes act without commit
// R9: Rate bit picks 256 or 558 Hz
// R10: Enable bit 7 picks logarithmic scale
// R11: Host waits, sets chip enable, waits
// R12: Config write 01h selects internal clock
// R13: Duty registers reset to zero
// R14: Engine mode field four encodings
// R15: Disabled engine drives mapped outputs dark
// R16: Log curve monotonic, zero off, full on
// R17: Shared eight-bit counter compared per output
`timescale 1ns/1ns
`default_nettype none
module led_channel_pwm_current_control
    import led_pwm_pkg::*;
#(
    parameter logic [6:0] BUS_ADDRESS = BUS_ADDR_RESET // Arbitrary base, low two bits from pins
) (
    input wire logic clock, // 100 MHz system clock
    input wire logic rst, // Synchronous reset, high
    input wire logic scl, // Serial bus clock
    input wire logic sda_in, // Serial data line level
    output logic sda_out, // Serial data drive value
    output logic sda_oe, // Serial data pull-low enable
    input wire logic [1:0] addr_sel, // Bus address select pins
    input wire logic external_slow_clock_in, // External 32 kHz time base
    input wire logic [2:0][7:0] engine_run_duty, // Program output per engine
    output logic [3:0] led_pwm, // PWM gate per output
    output var chan_bytes_s sink_current // Current code per output
);
    bus_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic nack_reg;
    logic wr_en_reg;
    logic sda_oe_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] rd_next;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic [6:0] own_addr;

    logic [7:0] enable_reg;
    logic [5:0] mode_reg;
    logic [7:0] config_reg;
    logic [7:0] map_reg;
    logic [3:0][7:0] duty_reg;
    logic [3:0][7:0] current_reg;

    logic [10:0] div_cnt_reg;
    logic [10:0] div_last;
    logic use_internal;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic tick;
    logic [7:0] pwm_count_reg;
    logic [2:0][7:0] eng_duty_reg;
    logic any_load;
    logic [3:0][7:0] sel_duty;
    logic [3:0] on_bits;
    logic [3:0] led_pwm_reg;

    localparam logic [10:0] SLOW_LAST = 11'(SLOW_DIV - 1);
    localparam logic [10:0] FAST_LAST = 11'(FAST_DIV - 1);

    function automatic engine_mode_e mode_of(input logic [5:0] m, input int e);
        logic [1:0] f;
        f = (e == 0) ? m[FIRST_ENGINE_POS +: 2] : (e == 1) ? m[SECOND_ENGINE_POS +: 2] : m[THIRD_ENGINE_POS +: 2];
        return engine_mode_e'(f);
    endfunction : mode_of

    function automatic source_e source_of(input logic [7:0] m, input int ch);
        return source_e'(m[ch*SELECT_WIDTH +: SELECT_WIDTH]);
    endfunction : source_of

    assign own_addr = {BUS_ADDRESS[6:2], addr_sel};
    assign scl_rise = !scl_q_reg && scl;
    assign scl_fall = scl_q_reg && !scl;
    assign start_seen = scl_q_reg && scl && sda_q_reg && !sda_in;
    assign stop_seen = scl_q_reg && scl && !sda_q_reg && sda_in;

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl;
            sda_q_reg <= sda_in;
        end
    end

    // Bytes shift in on scl rise; the line is only changed on scl fall, or released at START or STOP
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            wr_en_reg <= 1'b0;
            if (start_seen) begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg <= 1'b0;
            end else if (stop_seen) begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else if (scl_rise) begin
                case (state_reg)
                    ST_ADDR, ST_REG, ST_WRITE: begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    ST_READ: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    ST_READ_ACK: nack_reg <= sda_in;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR: if (bit_cnt_reg == 4'h8) begin
                        if (shift_reg[7:1] == own_addr) begin
                            rw_reg <= shift_reg[0];
                            sda_oe_reg <= 1'b1;
                            state_reg <= ST_ADDR_ACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_REG: if (bit_cnt_reg == 4'h8) begin
                        ptr_reg <= shift_reg;
                        sda_oe_reg <= 1'b1;
                        state_reg <= ST_REG_ACK;
                    end
                    ST_WRITE: if (bit_cnt_reg == 4'h8) begin
                        wr_en_reg <= 1'b1;
                        sda_oe_reg <= 1'b1;
                        state_reg <= ST_WRITE_ACK;
                    end
                    ST_REG_ACK, ST_WRITE_ACK: begin
                        if (state_reg == ST_WRITE_ACK) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        sda_oe_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_WRITE;
                    end
                    ST_ADDR_ACK, ST_READ_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR_ACK && !rw_reg) begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_REG;
                        end else if (state_reg == ST_READ_ACK && nack_reg) begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            shift_reg <= rd_next;
                            sda_oe_reg <= !rd_next[7];
                            ptr_reg <= ptr_reg + 8'h01;
                            state_reg <= ST_READ;
                        end
                    end
                    ST_READ: if (bit_cnt_reg == 4'h8) begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_READ_ACK;
                    end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= !shift_reg[6];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Open drain: the driven value is always low, only the enable moves
    always_ff @(posedge clock) begin
        sda_out <= 1'b0;
    end
    assign sda_oe = sda_oe_reg;

    // Unmapped addresses read zero; lower channel index wins on a shared address
    always_comb begin
        rd_next = 8'h00;
        if (ptr_reg == ENABLE_ADDR) begin
            rd_next = enable_reg;
        end else if (ptr_reg == MODE_ADDR) begin
            rd_next = {2'b00, mode_reg};
        end else if (ptr_reg == CONFIG_ADDR) begin
            rd_next = config_reg;
        end else if (ptr_reg == MAP_ADDR) begin
            rd_next = map_reg;
        end else begin
            for (int i = 3; i >= 0; i--) begin
                if (ptr_reg == DUTY_ADDRS[i]) rd_next = duty_reg[i];
                if (ptr_reg == CUR_ADDRS[i]) rd_next = current_reg[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            enable_reg <= CTRL_RESET;
            mode_reg <= 6'h00;
            config_reg <= CTRL_RESET;
            map_reg <= CTRL_RESET;
        end else if (wr_en_reg) begin
            if (ptr_reg == ENABLE_ADDR) enable_reg <= shift_reg; // [R10]
            if (ptr_reg == MODE_ADDR) mode_reg <= shift_reg[5:0]; // [R14]
            if (ptr_reg == CONFIG_ADDR) begin
                config_reg <= shift_reg & 8'h41; // [R9] [R12]
            end
            if (ptr_reg == MAP_ADDR) map_reg <= shift_reg; // [R5]
        end
    end

    // A write lands in the duty register and reaches the compare next cycle
    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                duty_reg[i] <= DUTY_RESET; // [R13]
                current_reg[i] <= CURRENT_RESET; // [R2]
            end else if (wr_en_reg) begin
                if (ptr_reg == DUTY_ADDRS[i]) duty_reg[i] <= shift_reg; // [R3] [R8]
                if (ptr_reg == CUR_ADDRS[i]) current_reg[i] <= shift_reg; // [R1]
            end
        end
    end
    assign sink_current = chan_bytes_s'(current_reg); // [R1]

    // The fast rate cannot be reached from the slow external clock, so it always uses the divider
    assign use_internal = config_reg[INT_CLK_BIT] || config_reg[FAST_RATE_BIT]; // [R12]
    assign div_last = config_reg[FAST_RATE_BIT] ? FAST_LAST : SLOW_LAST; // [R9]
    assign tick = use_internal ? (div_cnt_reg >= div_last) : (ext_sync_reg != ext_prev_reg);

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= external_slow_clock_in;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !use_internal || div_cnt_reg >= div_last) begin
            div_cnt_reg <= 11'h000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pwm_count_reg <= 8'h00;
        end else if (tick) begin
            pwm_count_reg <= pwm_count_reg + 8'h01; // [R17]
        end
    end

    // Any engine loading freezes itself and every running engine; off and direct engines still update
    always_comb begin
        any_load = 1'b0;
        for (int e = 0; e < 3; e++) begin
            if (mode_of(mode_reg, e) == MODE_LOAD) any_load = 1'b1;
        end
    end

    for (genvar e = 0; e < 3; e++) begin : g_engine
        always_ff @(posedge clock) begin
            if (rst) begin
                eng_duty_reg[e] <= DUTY_RESET;
            end else begin
                case (mode_of(mode_reg, e))
                    MODE_OFF: eng_duty_reg[e] <= DUTY_RESET; // [R15]
                    MODE_LOAD: eng_duty_reg[e] <= eng_duty_reg[e];
                    MODE_RUN: if (!any_load) eng_duty_reg[e] <= engine_run_duty[e];
                    MODE_DIRECT: eng_duty_reg[e] <= duty_reg[e]; // [R7]
                    default: eng_duty_reg[e] <= DUTY_RESET;
                endcase
            end
        end
    end

    for (genvar c = 0; c < 4; c++) begin : g_channel
        always_comb begin
            case (source_of(map_reg, c))
                SRC_OWN: sel_duty[c] = duty_reg[c]; // [R6]
                SRC_ENG1: sel_duty[c] = eng_duty_reg[0];
                SRC_ENG2: sel_duty[c] = eng_duty_reg[1];
                default: sel_duty[c] = eng_duty_reg[2];
            endcase
        end
        channel_drive #(.WIDTH(8)) u_drive (
            .duty(sel_duty[c]),
            .log_scale(enable_reg[LOG_EN_BIT]),
            .count(pwm_count_reg),
            .on(on_bits[c])
        );
    end

    // Chip enable low keeps every sink dark whatever the duty
    always_ff @(posedge clock) begin
        if (rst) begin
            led_pwm_reg <= 4'h0;
        end else begin
            led_pwm_reg <= on_bits & {4{enable_reg[CHIP_EN_BIT]}}; // [R4]
        end
    end
    assign led_pwm = led_pwm_reg;

    a_current_reset: assert property (@(posedge clock) $past(rst) |-> current_reg == {4{CURRENT_RESET}}) // [R2]
        else $error("current code not at reset value");
    a_duty_reset: assert property (@(posedge clock) $past(rst) |-> duty_reg == 32'h0) // [R13]
        else $error("duty register not cleared by reset");
    a_duty_zero_off: assert property (@(posedge clock) disable iff (rst)
        $past(map_reg[1:0] == 2'b00 && duty_reg[0] == 8'h00) |-> !led_pwm[0]) // [R4]
        else $error("blue lit with zero duty");
    a_duty_full_on: assert property (@(posedge clock) disable iff (rst)
        $past(enable_reg[CHIP_EN_BIT] && map_reg[1:0] == 2'b00 && duty_reg[0] == 8'hff) |-> led_pwm[0]) // [R4] [R16]
        else $error("blue dark with full duty");
    a_engine_off_dark: assert property (@(posedge clock) disable iff (rst)
        (map_reg[3:2] == 2'b10 && mode_reg[3:2] == 2'b00) [*3] |-> !led_pwm[1]) // [R15]
        else $error("green lit from disabled engine");
    a_direct_follow: assert property (@(posedge clock) disable iff (rst)
        $past(mode_reg[5:4] == 2'b11) |-> eng_duty_reg[0] == $past(duty_reg[0])) // [R7]
        else $error("direct engine ignores blue duty");
    a_duty_write: assert property (@(posedge clock) disable iff (rst)
        wr_en_reg && ptr_reg == BLUE_PWM_ADDR |=> duty_reg[0] == $past(shift_reg)) // [R3] [R8]
        else $error("blue duty write lost");
    a_map_write: assert property (@(posedge clock) disable iff (rst)
        wr_en_reg && ptr_reg == MAP_ADDR |=> map_reg == $past(shift_reg)) // [R5]
        else $error("map write lost");
    a_rate_slow: assert property (@(posedge clock) disable iff (rst)
        config_reg == 8'h01 && div_cnt_reg == SLOW_LAST |=> pwm_count_reg == $past(pwm_count_reg) + 8'h01) // [R9] [R17]
        else $error("slow rate step missing");
    a_clock_select: assert property (@(posedge clock) disable iff (rst)
        wr_en_reg && ptr_reg == CONFIG_ADDR && shift_reg == 8'h01 |=> use_internal) // [R12]
        else $error("internal clock not selected");

    c_full_duty: cover property (@(posedge clock) disable iff (rst) duty_reg[0] == 8'hff && led_pwm[0]);
    c_engine_direct: cover property (@(posedge clock) disable iff (rst) mode_reg[5:4] == 2'b11 && map_reg == 8'h79);
    c_read_byte: cover property (@(posedge clock) disable iff (rst) state_reg == ST_READ_ACK);
endmodule : led_channel_pwm_current_control
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// Purpose: Two-wire bus host that reads and writes the block's registers
// Assumes: the data wire has a pull-up, so releasing it reads back high
// Notes: each bus phase lasts 4 clocks, above the 3-clock minimum
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    input wire logic clock, // System clock, host steps on its falling edge
    input wire logic sda_line, // Resolved data wire level
    output var logic scl, // Bus clock
    output var logic sda_drv // Host data drive, 1 releases the wire
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hold();
        repeat (4) @(negedge clock);
    endtask : hold

    task automatic start();
        sda_drv = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b0;
        hold();
        scl = 1'b0;
        hold();
    endtask : start

    task automatic stop();
        sda_drv = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b1;
        hold();
    endtask : stop

    // Data changes only while scl is low, so it can never look like START or STOP
    task automatic clock_bit(input logic b, output logic seen);
        sda_drv = b;
        hold();
        scl = 1'b1;
        hold();
        seen = sda_line;
        scl = 1'b0;
        hold();
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(last, s);
    endtask : recv_byte

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({dev, 1'b0}, a0);
        send_byte(a, a1);
        send_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({dev, 1'b0}, a0);
        send_byte(a, a1);
        start();
        send_byte({dev, 1'b1}, a2);
        recv_byte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

/* File: tb/test_led_channel_pwm_current_control.sv */
// Purpose: Register-level bench for the four-channel PWM and current block
// Assumes: external time base toggles every 4 clocks, so one PWM period is 1024 clocks
// Notes: on-time per period is duty level times 4 clocks, all 1024 clocks for the full code, counted over a full period
`timescale 1ns/1ns
`default_nettype none
module test_led_channel_pwm_current_control
    import led_pwm_pkg::*;
();
    localparam logic [6:0] DEV = {BUS_ADDR_RESET[6:2], 2'b01};
    localparam logic [3:0][7:0] DUTY = {8'h00, 8'h80, 8'hc0, 8'hff};
    logic clock, rst, scl, sda_drv, sda_line, sda_out, sda_oe, external_slow_clock_in;
    logic [2:0][7:0] engine_run_duty;
    logic [3:0] led_pwm;
    chan_bytes_s sink_current;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    assign sda_line = sda_drv & ~sda_oe;

    led_channel_pwm_current_control #(.BUS_ADDRESS(BUS_ADDR_RESET)) u_led_channel_pwm_current_control (
        .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel(2'b01), .external_slow_clock_in(external_slow_clock_in),
        .engine_run_duty(engine_run_duty), .led_pwm(led_pwm), .sink_current(sink_current));

    i2c_host_model u_i2c_host_model (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    initial clock = 1'b0;
    always #5 clock = ~clock;

    always begin
        repeat (4) @(negedge clock);
        external_slow_clock_in = ~external_slow_clock_in;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Whole run needs about 20000 clocks
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_i2c_host_model.write_reg(DEV, a, d, ok);
        // Acknowledged, and the open-drain drive value is low once the write ends
        check(32'({ok, sda_out}), 32'h2);
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_i2c_host_model.read_reg(DEV, a, d, ok);
        check(32'({ok, d}), 32'({1'b1, exp}));
    endtask : rd_check

    // Any 1024 consecutive clocks hold each counter value exactly 4 clocks
    task automatic measure(input logic [3:0][15:0] exp);
        logic [3:0][15:0] cnt;
        cnt = '0;
        repeat (16) @(negedge clock);
        repeat (1024) begin
            @(negedge clock);
            for (int i = 0; i < 4; i++) begin
                cnt[i] = cnt[i] + 16'(led_pwm[i]);
            end
        end
        for (int i = 0; i < 4; i++) begin
            check(32'(cnt[i]), 32'(exp[i]));
        end
    endtask : measure

    initial begin
        rst = 1'b1;
        external_slow_clock_in = 1'b0;
        engine_run_duty = '0;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check(32'(sink_current), {4{CURRENT_RESET}});
        check(32'(led_pwm), 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd_check(DUTY_ADDRS[i], DUTY_RESET);
        end
        $display("test reset done");
        wr(ENABLE_ADDR, 8'h40);
        wr(MAP_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(DUTY_ADDRS[i], DUTY[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_check(DUTY_ADDRS[i], DUTY[i]);
        end
        rd_check(8'h50, 8'h00);
        measure({16'd0, 16'd512, 16'd768, 16'd1024});
        $display("test own duty done");
        wr(ENABLE_ADDR, 8'hc0);
        measure({16'd0, 16'd260, 16'd580, 16'd1024});
        wr(ENABLE_ADDR, 8'h40);
        $display("test log scale done");
        wr(MODE_ADDR, 8'h30);
        wr(MAP_ADDR, 8'h79);
        measure({16'd1024, 16'd0, 16'd0, 16'd1024});
        engine_run_duty[1] = 8'h40;
        wr(MODE_ADDR, 8'h3b);
        measure({16'd1024, 16'd512, 16'd256, 16'd1024});
        // Engine 3 loading freezes the running engine 2 at its last duty
        wr(MODE_ADDR, 8'h39);
        engine_run_duty[1] = 8'h80;
        measure({16'd1024, 16'd512, 16'd256, 16'd1024});
        $display("test engine map done");
        wr(BLUE_CUR_ADDR, 8'hff);
        wr(WHITE_CUR_ADDR, 8'h00);
        wr(GREEN_CUR_ADDR, 8'h12);
        check(32'(sink_current), 32'h001212ff);
        rd_check(BLUE_CUR_ADDR, 8'hff);
        $display("test current done");
        // Long enough for the internal slow divider to wrap at least once
        wr(CONFIG_ADDR, 8'h01);
        repeat (2000) @(negedge clock);
        rd_check(CONFIG_ADDR, 8'h01);
        wr(CONFIG_ADDR, 8'h41);
        rd_check(CONFIG_ADDR, 8'h41);
        $display("test config done");
        give_verdict();
    end
endmodule : test_led_channel_pwm_current_control
`default_nettype wire
